// ===== bsaa_core.v
// Notes on behaviour
// - start flag bit 1 of first byte begins selected block
// - started sequence runs on without further host commands
// - first executed opcode is attribute 1 of requested block instance
// - next block taken from link attribute; link zero stops sequence
// - busy flag is one while any block of sequence executes
// - busy flag clears once final block completes
// - block storage holds instances 1 through 255
// - reply echoes MAC byte, service with bit 7 set, data
// - read service 0x0E on 0x25/1/8 returns four-byte acceleration
// - present position readable as 0x25 instance 1 attribute 13
// - connection 1 carries explicit, connection 2 polled messages
// - link value zero marks current block as the last
// - block changes refused while executing or alarm active
`timescale 1ns/100ps
`default_nettype none
`include "bsaa_regs.vh"
module bsaa_core #(
  parameter AW = 8
) (
  input  wire        sys_clk_i,
  input  wire        reset_i,
  input  wire        poll_valid_i,
  input  wire [7:0]  poll_conn_i,
  input  wire [7:0]  poll_byte0_i,
  input  wire [7:0]  poll_byte1_i,
  input  wire        exp_valid_i,
  input  wire [7:0]  exp_conn_i,
  input  wire [7:0]  exp_data_i,
  input  wire        exp_last_i,
  output wire        exp_ready_o,
  output wire        resp_valid_o,
  output wire [7:0]  resp_data_o,
  output wire        resp_last_o,
  input  wire        resp_ready_i,
  output wire        exec_start_o,
  output wire [7:0]  exec_opcode_o,
  output wire [7:0]  exec_block_o,
  input  wire        exec_done_i,
  input  wire        alarm_i,
  input  wire [31:0] accel_i,
  input  wire [31:0] position_i,
  output wire        block_busy_o
);
  // ==============================================
  // sequencer states
  localparam S_IDLE  = 2'b00;
  localparam S_ISSUE = 2'b01;
  localparam S_RUN   = 2'b10;
  // explicit message states
  localparam E_RX   = 2'b00;
  localparam E_MEM  = 2'b01;
  localparam E_RESP = 2'b10;
  localparam E_TX   = 2'b11;

  // a real block instance, never instance zero
  function cb_target;
    input [7:0] cls;
    input [7:0] inst;
    begin
      cb_target = (cls == `BSAA_CLASS_CMDBLK) && (inst != `BSAA_BLOCK_NONE);
    end
  endfunction

  reg  [1:0]  seq_reg;
  reg  [1:0]  seq_next;
  reg  [7:0]  blk_reg;
  reg  [7:0]  link_reg;
  reg  [7:0]  op_reg;
  reg         busy_reg;
  reg         go_reg;
  reg         start_prev_reg;
  reg  [1:0]  ex_reg;
  reg  [55:0] req_reg;
  reg  [2:0]  rcnt_reg;
  reg  [47:0] rbuf_reg;
  reg  [2:0]  rleft_reg;
  wire [15:0] rda_data;
  wire [15:0] rdb_data;
  wire [7:0]  rda_addr;
  wire        poll_take;
  wire        start_req;

  // ==============================================
  // polled start request
  // polled connection check
  assign poll_take = poll_valid_i && (poll_conn_i == `BSAA_CONN_POLLED);
  assign start_req = poll_take && poll_byte0_i[`BSAA_POLL_VALID_BIT]
                     && poll_byte0_i[`BSAA_POLL_START_BIT] && !start_prev_reg
                     && (poll_byte1_i != `BSAA_BLOCK_NONE);

  // edge memory; a held start flag must not restart a sequence
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      start_prev_reg <= 1'b0;
    end else if (poll_take) begin
      start_prev_reg <= poll_byte0_i[`BSAA_POLL_START_BIT];
    end
  end

  // ==============================================
  // block sequencer
  // fetch address is the block instance
  assign rda_addr = (seq_reg == S_IDLE) ? poll_byte1_i : link_reg;

  always @* begin
    seq_next = seq_reg;
    case (seq_reg)
      S_IDLE: begin
        if (start_req) begin
          seq_next = S_ISSUE;
        end
      end
      S_ISSUE: begin
        seq_next = S_RUN;
      end
      S_RUN: begin
        if (exec_done_i) begin
          seq_next = (link_reg == `BSAA_LINK_END) ? S_IDLE : S_ISSUE;
        end
      end
      default: begin
        seq_next = S_IDLE;
      end
    endcase
  end

  // one block in flight at a time; executor answers with done
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      seq_reg  <= S_IDLE;
      blk_reg  <= 8'h00;
      link_reg <= 8'h00;
      op_reg   <= 8'h00;
      busy_reg <= 1'b0;
      go_reg   <= 1'b0;
    end else begin
      seq_reg <= seq_next;
      go_reg  <= 1'b0;
      case (seq_reg)
        S_IDLE: begin
          if (start_req) begin
            blk_reg  <= poll_byte1_i;
            busy_reg <= 1'b1;
          end
        end
        S_ISSUE: begin
          op_reg   <= rda_data[7:0];
          link_reg <= rda_data[15:8];
          go_reg   <= 1'b1;
        end
        S_RUN: begin
          if (exec_done_i) begin
            if (link_reg == `BSAA_LINK_END) begin
              busy_reg <= 1'b0;
            end else begin
              blk_reg <= link_reg;
            end
          end
        end
        default: begin
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  assign exec_start_o  = go_reg;
  assign exec_opcode_o = op_reg;
  assign exec_block_o  = blk_reg;
  assign block_busy_o  = busy_reg;

  // ==============================================
  // explicit request decode
  wire [7:0] q_mac  = req_reg[8*`BSAA_IX_MAC   +: 8];
  wire [6:0] q_svc  = req_reg[8*`BSAA_IX_SVC   +: 7];
  wire [7:0] q_cls  = req_reg[8*`BSAA_IX_CLASS +: 8];
  wire [7:0] q_inst = req_reg[8*`BSAA_IX_INST  +: 8];
  wire [7:0] q_attr = req_reg[8*`BSAA_IX_ATTR  +: 8];
  wire [7:0] q_dat  = req_reg[8*`BSAA_IX_DATA  +: 8];
  wire       rx_take = (ex_reg == E_RX) && exp_valid_i
                       && (exp_conn_i == `BSAA_CONN_EXPLICIT);

  reg [47:0] rb_next;
  reg [2:0]  rl_next;
  reg        wr_en;
  reg [1:0]  wr_be;
  reg [15:0] wr_data;

  // reply image and store write, all decided in one cycle
  always @* begin
    rb_next = {40'h00_0000_0000, q_mac};
    rl_next = 3'h2;
    wr_en   = 1'b0;
    wr_be   = 2'b00;
    wr_data = 16'h0000;
    // reply service with bit 7 set
    rb_next[15:8] = `BSAA_REPLY_BIT | {1'b0, q_svc};
    case (q_svc)
      `BSAA_SVC_GET_SINGLE: begin
        rl_next = 3'h3;
        if (rcnt_reg < `BSAA_LEN_GET) begin
          rl_next = 3'h0;
        end else if (q_cls == `BSAA_CLASS_POSCTL && q_inst == `BSAA_INST_ONE
                     && q_attr == `BSAA_ATTR_ACCEL) begin
          rb_next[47:16] = accel_i;
          rl_next = 3'h6;
        end else if (q_cls == `BSAA_CLASS_POSCTL && q_inst == `BSAA_INST_ONE
                     && q_attr == `BSAA_ATTR_POSITION) begin
          rb_next[47:16] = position_i;
          rl_next = 3'h6;
        end else if (cb_target(q_cls, q_inst) && q_attr == `BSAA_ATTR_OPCODE) begin
          rb_next[23:16] = rdb_data[7:0];
        end else if (cb_target(q_cls, q_inst) && q_attr == `BSAA_ATTR_LINK) begin
          rb_next[23:16] = rdb_data[15:8];
        end else begin
          rl_next = 3'h0;
        end
      end
      `BSAA_SVC_SET_SINGLE, `BSAA_SVC_SET_ALL: begin
        if (rcnt_reg < `BSAA_LEN_SET_SINGLE) begin
          rl_next = 3'h0;
        end else if (!cb_target(q_cls, q_inst)) begin
          rl_next = 3'h0;
        end else if (busy_reg || alarm_i) begin
          rl_next = 3'h1;
        end else if (q_svc == `BSAA_SVC_SET_ALL) begin
          wr_en   = 1'b1;
          wr_be   = 2'b11;
          wr_data = {q_dat, q_attr};
        end else if (q_attr == `BSAA_ATTR_OPCODE) begin
          // new opcode resets the rest of the block
          wr_en   = 1'b1;
          wr_be   = 2'b11;
          wr_data = {`BSAA_LINK_END, q_dat};
        end else if (q_attr == `BSAA_ATTR_LINK) begin
          wr_en   = 1'b1;
          wr_be   = 2'b10;
          wr_data = {q_dat, 8'h00};
        end else begin
          rl_next = 3'h0;
        end
      end
      default: begin
        rl_next = 3'h4;
        rb_next[15:8]  = `BSAA_REPLY_BIT | {1'b0, `BSAA_SVC_ERROR};
        rb_next[31:16] = {`BSAA_ERR_EXTRA, `BSAA_ERR_SERVICE};
      end
    endcase
    // error replies: codes 0 and 1 pick the general code
    if (rl_next < 3'h2) begin
      rb_next[15:8]  = `BSAA_REPLY_BIT | {1'b0, `BSAA_SVC_ERROR};
      rb_next[31:16] = {`BSAA_ERR_EXTRA,
                        (rl_next == 3'h1) ? `BSAA_ERR_STATE :
                        (rcnt_reg < ((q_svc == `BSAA_SVC_GET_SINGLE) ? `BSAA_LEN_GET
                                     : `BSAA_LEN_SET_SINGLE)) ? `BSAA_ERR_SHORT :
                        cb_target(q_cls, q_inst) ? `BSAA_ERR_ATTR :
                        `BSAA_ERR_OBJECT};
      rb_next[47:32] = 16'h0000;
      rl_next = 3'h4;
    end
  end

  // ==============================================
  // explicit message engine
  always @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ex_reg    <= E_RX;
      req_reg   <= 56'h00_0000_0000_0000;
      rcnt_reg  <= 3'h0;
      rbuf_reg  <= 48'h0000_0000_0000;
      rleft_reg <= 3'h0;
    end else begin
      case (ex_reg)
        E_RX: begin
          if (rx_take) begin
            if (rcnt_reg < `BSAA_REQ_BYTES) begin
              req_reg[8*rcnt_reg +: 8] <= exp_data_i;
              rcnt_reg <= rcnt_reg + 3'h1;
            end
            if (exp_last_i) begin
              ex_reg <= E_MEM;
            end
          end
        end
        E_MEM: begin
          // store read port settles on the instance address
          ex_reg <= E_RESP;
        end
        E_RESP: begin
          rbuf_reg  <= rb_next;
          rleft_reg <= rl_next;
          ex_reg    <= E_TX;
        end
        E_TX: begin
          // reply shifts out one byte per accepted beat
          if (resp_ready_i) begin
            rbuf_reg  <= {8'h00, rbuf_reg[47:8]};
            rleft_reg <= rleft_reg - 3'h1;
            if (rleft_reg == 3'h1) begin
              ex_reg   <= E_RX;
              rcnt_reg <= 3'h0;
              req_reg  <= 56'h00_0000_0000_0000;
            end
          end
        end
        default: begin
          ex_reg <= E_RX;
        end
      endcase
    end
  end

  assign exp_ready_o  = (ex_reg == E_RX);
  assign resp_valid_o = (ex_reg == E_TX);
  assign resp_data_o  = rbuf_reg[7:0];
  assign resp_last_o  = (ex_reg == E_TX) && (rleft_reg == 3'h1);

  // ==============================================
  // block store, instances 1 to 255
  bsaa_cbmem #(
    .AW(AW),
    .LW(8),
    .NL(2)
  ) u_store (
    .sys_clk_i  (sys_clk_i),
    .wr_en_i    (wr_en && (ex_reg == E_RESP)),
    .wr_be_i    (wr_be),
    .wr_addr_i  (q_inst[AW-1:0]),
    .wr_data_i  (wr_data),
    .rda_addr_i (rda_addr[AW-1:0]),
    .rda_data_o (rda_data),
    .rdb_addr_i (q_inst[AW-1:0]),
    .rdb_data_o (rdb_data)
  );
endmodule // bsaa_core
`default_nettype wire

// ===== bsaa_regs.vh
`ifndef BSAA_REGS_VH
`define BSAA_REGS_VH
// ==============================================
// polled command message layout
`define BSAA_POLL_VALID_BIT 6
`define BSAA_POLL_START_BIT 1
`define BSAA_CONN_EXPLICIT  8'h01
`define BSAA_CONN_POLLED    8'h02
// ==============================================
// explicit message layout
`define BSAA_REQ_BYTES      7
`define BSAA_IX_MAC         0
`define BSAA_IX_SVC         1
`define BSAA_IX_CLASS       2
`define BSAA_IX_INST        3
`define BSAA_IX_ATTR        4
`define BSAA_IX_DATA        5
`define BSAA_LEN_GET        3'h5
`define BSAA_LEN_SET_SINGLE 3'h6
`define BSAA_LEN_SET_ALL    3'h6
`define BSAA_REPLY_BIT      8'h80
// ==============================================
// service codes
`define BSAA_SVC_GET_SINGLE 7'h0E
`define BSAA_SVC_SET_SINGLE 7'h10
`define BSAA_SVC_SET_ALL    7'h02
`define BSAA_SVC_ERROR      7'h14
// ==============================================
// general and extra error codes of an error reply
`define BSAA_ERR_STATE      8'h0C
`define BSAA_ERR_SERVICE    8'h08
`define BSAA_ERR_ATTR       8'h14
`define BSAA_ERR_SHORT      8'h13
`define BSAA_ERR_OBJECT     8'h16
`define BSAA_ERR_EXTRA      8'hFF
// ==============================================
// object addressing
`define BSAA_CLASS_POSCTL   8'h25
`define BSAA_CLASS_CMDBLK   8'h27
`define BSAA_INST_ONE       8'h01
`define BSAA_ATTR_OPCODE    8'h01
`define BSAA_ATTR_LINK      8'h02
`define BSAA_ATTR_ACCEL     8'h08
`define BSAA_ATTR_POSITION  8'h0D
`define BSAA_LINK_END       8'h00
`define BSAA_BLOCK_NONE     8'h00
`endif

// ===== bsaa_cbmem.v
`timescale 1ns/100ps
`default_nettype none
// ==============================================
// command block store, two registered read ports
module bsaa_cbmem #(
  parameter AW = 8,
  parameter LW = 8,
  parameter NL = 2
) (
  input  wire             sys_clk_i,
  input  wire             wr_en_i,
  input  wire [NL-1:0]    wr_be_i,
  input  wire [AW-1:0]    wr_addr_i,
  input  wire [NL*LW-1:0] wr_data_i,
  input  wire [AW-1:0]    rda_addr_i,
  output wire [NL*LW-1:0] rda_data_o,
  input  wire [AW-1:0]    rdb_addr_i,
  output wire [NL*LW-1:0] rdb_data_o
);
  genvar g;
  // one array per byte lane, so lanes write alone
  generate
    for (g = 0; g < NL; g = g + 1) begin : lane
      reg [LW-1:0] mem [0:(1<<AW)-1];
      reg [LW-1:0] qa_reg;
      reg [LW-1:0] qb_reg;
      always @(posedge sys_clk_i) begin
        if (wr_en_i && wr_be_i[g]) begin
          mem[wr_addr_i] <= wr_data_i[g*LW +: LW];
        end
        qa_reg <= mem[rda_addr_i];
        qb_reg <= mem[rdb_addr_i];
      end
      assign rda_data_o[g*LW +: LW] = qa_reg;
      assign rdb_data_o[g*LW +: LW] = qb_reg;
    end
  endgenerate
endmodule // bsaa_cbmem
`default_nettype wire

// ===== bsaa_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// port checker for the sequencer core
module bsaa_checker #(
  parameter AW = 8
) (
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  input wire logic       poll_valid_i,
  input wire logic [7:0] poll_conn_i,
  input wire logic [7:0] poll_byte0_i,
  input wire logic [7:0] poll_byte1_i,
  input wire logic       exp_valid_i,
  input wire logic       exp_last_i,
  input wire logic       exp_ready_o,
  input wire logic       resp_valid_o,
  input wire logic [7:0] resp_data_o,
  input wire logic       resp_last_o,
  input wire logic       resp_ready_i,
  input wire logic       exec_start_o,
  input wire logic [7:0] exec_block_o,
  input wire logic       exec_done_i,
  input wire logic       block_busy_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  // ==========================================
  // sequencer
  AST_START_CAUSE: assert property ($rose(block_busy_o) |->
    $past(poll_valid_i && poll_conn_i == 8'h02 && poll_byte0_i[6] && poll_byte0_i[1] && poll_byte1_i != 8'h00))
    else $error("busy rose without a valid start");
  AST_FIRST_BLOCK: assert property ($rose(block_busy_o) |=>
    exec_start_o && exec_block_o == $past(poll_byte1_i, 2)) else $error("first block not issued");
  AST_EXEC_BUSY: assert property (exec_start_o |-> block_busy_o)
    else $error("block issued while not busy");
  AST_EXEC_PULSE: assert property (exec_start_o |=> !exec_start_o)
    else $error("issue pulse too long");
  AST_BUSY_END: assert property ($fell(block_busy_o) |-> $past(exec_done_i))
    else $error("busy dropped without done");
  AST_NEXT_BLOCK: assert property (exec_done_i && block_busy_o && !exec_start_o |->
    ##2 (exec_start_o || !block_busy_o)) else $error("no next block or stop after done");
  // ==========================================
  // explicit message path
  AST_REPLY_LAT: assert property (exp_valid_i && exp_ready_o && exp_last_i |=>
    !resp_valid_o [*2] ##1 resp_valid_o) else $error("reply latency wrong");
  AST_READY_DROP: assert property (exp_valid_i && exp_ready_o && exp_last_i |=> !exp_ready_o)
    else $error("request taken during reply");
  AST_REPLY_HOLD: assert property (resp_valid_o && !resp_ready_i |=>
    resp_valid_o && $stable(resp_data_o) && $stable(resp_last_o)) else $error("reply byte not held");
  AST_READY_BACK: assert property (resp_valid_o && resp_ready_i && resp_last_o |=>
    exp_ready_o && !resp_valid_o) else $error("engine not idle after reply");
endmodule // bsaa_checker

bind bsaa_core bsaa_checker #(.AW(AW)) u_chk (.*);
`default_nettype wire

// ===== bsaa_host.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// host model: sends requests, drains replies
module bsaa_host (
  input  wire logic       sys_clk_i,
  input  wire logic       exp_ready_i,
  input  wire logic       resp_valid_i,
  input  wire logic [7:0] resp_data_i,
  input  wire logic       resp_last_i,
  output var  logic       exp_valid_o,
  output var  logic [7:0] exp_conn_o,
  output var  logic [7:0] exp_data_o,
  output var  logic       exp_last_o,
  output var  logic       resp_ready_o
);
  logic [7:0] rsp [$];
  // idle at time zero, explicit connection
  initial begin
    exp_valid_o = 1'b0;
    exp_conn_o = 8'h01;
    exp_data_o = 8'h00;
    exp_last_o = 1'b0;
    resp_ready_o = 1'b0;
  end
  // called just after an edge; lag stalls each reply byte
  task automatic xfer(input logic [55:0] q, input int n, input int lag);
    int i;
    logic [7:0] d;
    logic l;
    rsp.delete();
    l = 1'b0;
    for (i = 0; i < n; i++) begin
      exp_valid_o = 1'b1;
      exp_data_o = q[55-8*i -: 8];
      exp_last_o = (i == n - 1);
      do begin
        d[0] = exp_ready_i;
        @(posedge sys_clk_i);
        #1;
      end while (!d[0]);
    end
    // released data line shows the inverse, never the old byte
    exp_valid_o = 1'b0;
    exp_last_o = 1'b0;
    exp_data_o = ~exp_data_o;
    // ready held up across back-to-back bytes, dropped to stall or while no reply byte is valid
    while (!l) begin
      if (resp_valid_i) begin
        repeat (lag) begin resp_ready_o = 1'b0; @(posedge sys_clk_i); #1; end
        d = resp_data_i;
        l = resp_last_i;
        resp_ready_o = 1'b1;
        rsp.push_back(d);
      end else begin
        resp_ready_o = 1'b0;
      end
      @(posedge sys_clk_i);
      #1;
    end
    resp_ready_o = 1'b0;
  endtask
endmodule // bsaa_host
`default_nettype wire

// ===== bsaa_core_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// core testbench
module bsaa_core_tb;
  logic sys_clk_i, reset_i, poll_valid_i, exec_done_i, alarm_i;
  logic [7:0] poll_conn_i, poll_byte0_i, poll_byte1_i;
  logic [31:0] accel_i, position_i;
  wire exp_valid_i, exp_last_i, resp_ready_i, exp_ready_o, resp_valid_o, resp_last_o;
  wire exec_start_o, block_busy_o;
  wire [7:0] exp_conn_i, exp_data_i, resp_data_o, exec_opcode_o, exec_block_o;
  int n_mismatch, n_checks;

  bsaa_core #(.AW(8)) u_dut (.*);
  bsaa_host u_host (.sys_clk_i(sys_clk_i), .exp_ready_i(exp_ready_o), .resp_valid_i(resp_valid_o),
    .resp_data_i(resp_data_o), .resp_last_i(resp_last_o), .exp_valid_o(exp_valid_i),
    .exp_conn_o(exp_conn_i), .exp_data_o(exp_data_i), .exp_last_o(exp_last_i), .resp_ready_o(resp_ready_i));

  // ==========================================
  // helpers
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one explicit exchange, reply packed left aligned
  task automatic ex(input logic [55:0] q, input int n, input int lag, input logic [47:0] e, input int m);
    int i;
    u_host.xfer(q, n, lag);
    chk(8'(u_host.rsp.size()), 8'(m));
    for (i = 0; i < m; i++) chk(u_host.rsp[i], e[47-8*i -: 8]);
  endtask
  // one polled message, then busy looked at a cycle later
  task automatic poll(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] c, input logic eb);
    poll_valid_i = 1'b1;
    poll_byte0_i = b0;
    poll_byte1_i = b1;
    poll_conn_i = c;
    @(posedge sys_clk_i);
    #1 poll_valid_i = 1'b0;
    @(posedge sys_clk_i);
    #1 chk(block_busy_o, eb);
  endtask
  // bounded wait for a block issue
  task automatic wx(input logic [7:0] op, input logic [7:0] blk);
    int i;
    for (i = 0; i < 8 && exec_start_o !== 1'b1; i++) begin @(posedge sys_clk_i); #1; end
    chk(exec_start_o, 1'b1);
    chk(exec_opcode_o, op);
    chk(exec_block_o, blk);
  endtask
  task automatic fin;
    exec_done_i = 1'b1;
    @(posedge sys_clk_i);
    #1 exec_done_i = 1'b0;
  endtask
  task automatic close_out;
    if (n_mismatch == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================
  // clock and watchdog, run needs under two hundred cycles
  initial begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    n_mismatch++;
    close_out;
  end

  // ==========================================
  // tests
  initial begin
    {reset_i, poll_valid_i, exec_done_i, alarm_i} = 4'h8;
    {poll_conn_i, poll_byte0_i, poll_byte1_i} = 24'h02_0000;
    accel_i = 32'h1122_3344;
    position_i = 32'hA1B2_C3D4;
    repeat (4) @(posedge sys_clk_i);
    #1 reset_i = 1'b0;
    chk(exp_ready_o, 1'b1);
    chk(block_busy_o, 1'b0);
    // chain 3 -> 5 -> end, second with a stalling sink
    ex(56'h0502_2703_0905_00, 6, 0, 48'h0582_0000_0000, 2);
    ex(56'h0502_2705_1000_00, 6, 2, 48'h0582_0000_0000, 2);
    // top instance; single opcode write clears the link
    ex(56'h0510_27FF_0108_00, 6, 0, 48'h0590_0000_0000, 2);
    ex(56'h050E_27FF_0200_00, 5, 0, 48'h058E_0000_0000, 3);
    ex(56'h3F0E_2501_0800_00, 5, 1, 48'h3F8E_4433_2211, 6);
    ex(56'h3F0E_2501_0D00_00, 5, 0, 48'h3F8E_D4C3_B2A1, 6);
    ex(56'h050E_2703_0100_00, 5, 0, 48'h058E_0900_0000, 3);
    // error replies: unknown service, short set, instance zero
    ex(56'h0505_2701_0100_00, 5, 0, 48'h0594_08FF_0000, 4);
    ex(56'h0510_2703_0100_00, 5, 0, 48'h0594_13FF_0000, 4);
    ex(56'h050E_2700_0100_00, 5, 0, 48'h0594_16FF_0000, 4);
    // refused starts leave the sequencer idle
    poll(8'h02, 8'h03, 8'h02, 1'b0);
    poll(8'h40, 8'h03, 8'h02, 1'b0);
    poll(8'h42, 8'h03, 8'h01, 1'b0);
    poll(8'h42, 8'h03, 8'h02, 1'b1);
    wx(8'h09, 8'h03);
    ex(56'h0502_2705_7733_00, 6, 0, 48'h0594_0CFF_0000, 4);
    fin();
    wx(8'h10, 8'h05);
    chk(block_busy_o, 1'b1);
    // done no earlier than the cycle after the issue pulse
    @(posedge sys_clk_i);
    #1 fin();
    @(posedge sys_clk_i);
    #1 chk(block_busy_o, 1'b0);
    poll(8'h42, 8'h03, 8'h02, 1'b0);
    alarm_i = 1'b1;
    ex(56'h0510_2705_0177_00, 6, 0, 48'h0594_0CFF_0000, 4);
    alarm_i = 1'b0;
    ex(56'h050E_2705_0100_00, 5, 0, 48'h058E_1000_0000, 3);
    close_out;
  end
endmodule // bsaa_core_tb
`default_nettype wire
